// ---- pkg/fsl_defines.svh ----
// Constants for the flash security lockout block
`ifndef FSL_DEFINES_SVH
`define FSL_DEFINES_SVH

// Register bus offsets
`define FSL_ADDR_W          4
`define FSL_OFF_CTRL        4'h0
`define FSL_OFF_STATUS      4'h1
`define FSL_OFF_CLKDIV      4'h2
`define FSL_OFF_KEY         4'h3
`define FSL_OFF_KEYCMP      4'h4
`define FSL_DATA_W          16

// Security byte encoding: secure unless both bytes hold the unsecure word
`define FSL_SEC_UNSEC_WORD  16'h0000

// JTAG instruction register
`define FSL_IR_W            4
`define FSL_IR_IDCODE       4'h2
`define FSL_IR_BYPASS       4'hf
`define FSL_IR_LOCKOUT      4'h8
`define FSL_IR_RESET_VAL    4'h2

// Lockout data register
`define FSL_DR_W            7
`define FSL_DR_PRDIV_BIT    6
`define FSL_DR_DIV_MSB      5

// Identification code, value is arbitrary
`define FSL_IDCODE_VAL      32'h1234_5001

// Erase duration in divided flash clock ticks; last count of the divide-by-eight prescaler
`define FSL_ERASE_TICKS     16'h0020
`define FSL_PRESCALE_DIV    4'h7

// Control register bits
`define FSL_CTRL_BACKDOOR_KEY_ENABLE_BIT  0

`endif

// ---- pkg/fsl_div_if.sv ----
// Flash clock divider request carried from the main block into the divider
`timescale 1ns/1ps
interface fsl_div_if;
  logic       run;
  logic       divide_by_eight_prescale;
  logic [5:0] div;
  logic       tick;
  modport ctl (output run, output divide_by_eight_prescale, output div, input tick);
  modport div_side (input run, input divide_by_eight_prescale, input div, output tick);
endinterface

// ---- pkg/fsl_pkg.sv ----
// Types for the flash security lockout block
package fsl_pkg;
  typedef enum logic [3:0] {
    FSL_TLR, FSL_RTI, FSL_SEL_DR, FSL_CAP_DR, FSL_SH_DR, FSL_EX1_DR, FSL_PAU_DR, FSL_EX2_DR, FSL_UPD_DR,
    FSL_SEL_IR, FSL_CAP_IR, FSL_SH_IR, FSL_EX1_IR, FSL_PAU_IR, FSL_EX2_IR, FSL_UPD_IR
  } fsl_tap_e;
  typedef enum logic [1:0] {FSL_ER_IDLE, FSL_ER_RUN, FSL_ER_DONE} fsl_erase_e;
endpackage

// ---- verification/fsl_jtag_host.sv ----
// JTAG host model that drives the test access port of the lockout block
`timescale 1ns/1ps
module fsl_jtag_host #(
  parameter int HALF = 8
) (
  // Clock
  input  wire logic core_clk,
  // JTAG pins
  output logic      trst_n,
  output logic      tck,
  output logic      tms,
  output logic      tdi,
  input  wire logic tdo
);
  initial begin
    trst_n = 1'b1;
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b1;
  end

  // One test clock period; tdo is sampled just before the rising edge
  task automatic step(input logic m, input logic d, output logic q);
    @(posedge core_clk);
    tms <= m;
    tdi <= d;
    repeat (HALF - 1) @(posedge core_clk);
    @(negedge core_clk);
    q = tdo;
    @(posedge core_clk);
    tck <= 1'b1;
    repeat (HALF) @(posedge core_clk);
    tck <= 1'b0;
  endtask

  // Starts in Run-Test/Idle or an Update state, ends in Update; idle bits toggle tdi
  task automatic shift(input logic ir, input int n, input logic [31:0] v, output logic [31:0] cap);
    logic q;
    cap = '0;
    step(1'b1, ~tdi, q);
    if (ir) step(1'b1, ~tdi, q);
    step(1'b0, ~tdi, q);
    step(1'b0, ~tdi, q);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, v[i], q);
      cap[i] = q;
    end
    step(1'b1, ~tdi, q);
  endtask

  // Park in Run-Test/Idle; the test clock then stands still, which holds the state
  task automatic idle();
    logic q;
    step(1'b0, ~tdi, q);
  endtask

  task automatic tap_reset();
    @(posedge core_clk);
    trst_n <= 1'b0;
    repeat (8) @(posedge core_clk);
    trst_n <= 1'b1;
    repeat (4) @(posedge core_clk);
  endtask
endmodule

// ---- verification/testbench.sv ----
// Self-checking testbench for the flash security lockout block
`timescale 1ns/1ps
`include "fsl_defines.svh"
module testbench;
  logic                   core_clk;
  logic                   sys_rst;
  logic                   clk_en;
  logic [`FSL_ADDR_W-1:0] reg_addr;
  logic [`FSL_DATA_W-1:0] reg_wdata;
  logic                   reg_wr;
  logic                   reg_rd;
  logic [`FSL_DATA_W-1:0] reg_rdata;
  logic [`FSL_DATA_W-1:0] sec_word;
  logic [`FSL_DR_W-1:0]   sw_flash_clkdiv;
  logic [`FSL_DR_W-1:0]   flash_clock_divider;
  logic                   flash_erase_done;
  logic                   trst_n;
  logic                   tck;
  logic                   tms;
  logic                   tdi;
  logic                   tdo;
  logic                   tdo_oe;
  logic                   dbg_read_disable;
  logic                   onchip_debug_port_en;
  logic                   flash_mass_erase;
  logic                   flash_div_tick;
  logic                   backdoor_key_ok;
  logic [31:0]            cap;
  logic [15:0]            words [4] = '{16'h0000, 16'h8000, 16'h0001, 16'hffff};
  int                     errors;
  int                     tests_run;

  fsl_lockout u_fsl_lockout (.core_clk, .sys_rst, .clk_en, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .sec_word, .sw_flash_clkdiv, .flash_erase_done, .trst_n, .tck, .tms, .tdi, .tdo, .tdo_oe,
    .dbg_read_disable, .onchip_debug_port_en, .flash_mass_erase, .flash_clock_divider, .flash_div_tick,
    .backdoor_key_ok);
  fsl_jtag_host u_fsl_jtag_host (.core_clk, .trst_n, .tck, .tms, .tdi, .tdo);

  initial core_clk = 1'b0;
  always #2 core_clk = ~core_clk;

  // ----------------------------------------
  // Bus and check tasks
  // ----------------------------------------
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic reg_write(input logic [3:0] a, input logic [15:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    @(negedge core_clk);
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd_chk(input string what, input logic [3:0] a, input logic [15:0] m, input logic [15:0] e);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(negedge core_clk);
    check(what, {16'h0, e}, {16'h0, reg_rdata & m});
  endtask

  task automatic do_reset(input logic [15:0] s);
    @(posedge core_clk);
    sys_rst <= 1'b1;
    sec_word <= s;
    repeat (3) @(posedge core_clk);
    sys_rst <= 1'b0;
    repeat (3) @(posedge core_clk);
    @(negedge core_clk);
  endtask

  // Distance in core cycles between two divided flash ticks
  task automatic tick_period(input int exp);
    int n;
    n = 0;
    while (flash_div_tick !== 1'b1 && n < 4000) begin
      @(negedge core_clk);
      n++;
    end
    n = 0;
    do begin
      @(negedge core_clk);
      n++;
    end while (flash_div_tick !== 1'b1 && n < 4000);
    check("tick period", 32'(exp), 32'(n));
  endtask

  task automatic lockout(input logic [6:0] dv);
    u_fsl_jtag_host.tap_reset();
    u_fsl_jtag_host.idle();
    u_fsl_jtag_host.shift(1'b1, `FSL_IR_W, 32'(`FSL_IR_LOCKOUT), cap);
    u_fsl_jtag_host.shift(1'b0, `FSL_DR_W, 32'(dv), cap);
    u_fsl_jtag_host.idle();
    repeat (4) @(negedge core_clk);
    check("erase running", 32'h1, 32'(flash_mass_erase));
    check("jtag divider", 32'(dv), 32'(flash_clock_divider));
    rd_chk("div loaded", `FSL_OFF_STATUS, 16'h0004, 16'h0004);
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Whole run is near 3.4k cycles; the 75k-cycle limit leaves wide margin
  initial begin
    #300000;
    errors++;
    $display("MISMATCH watchdog expected end seen timeout");
    finish_test();
  end

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    errors = 0;
    tests_run = 0;
    sys_rst = 1'b1;
    clk_en = 1'b1;
    reg_addr = '0;
    reg_wdata = '0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    sec_word = 16'hffff;
    sw_flash_clkdiv = 7'h2a;
    flash_erase_done = 1'b0;
    foreach (words[i]) begin
      do_reset(words[i]);
      check("read disable", 32'(words[i] != `FSL_SEC_UNSEC_WORD), 32'(dbg_read_disable));
      check("debug port", 32'(words[i] == `FSL_SEC_UNSEC_WORD), 32'(onchip_debug_port_en));
      rd_chk("secure flag", `FSL_OFF_STATUS, 16'h0001, 16'(words[i] != 16'h0));
    end
    sec_word <= `FSL_SEC_UNSEC_WORD;
    repeat (20) @(negedge core_clk);
    check("frozen disable", 32'h1, 32'(dbg_read_disable));
    $display("test boot_modes done");

    u_fsl_jtag_host.tap_reset();
    u_fsl_jtag_host.idle();
    u_fsl_jtag_host.shift(1'b1, `FSL_IR_W, 32'(`FSL_IR_IDCODE), cap);
    check("ir capture", 32'h1, cap);
    u_fsl_jtag_host.shift(1'b0, 32, 32'h0, cap);
    check("idcode", `FSL_IDCODE_VAL, cap);
    repeat (6) @(negedge core_clk);
    check("tdo released", 32'h0, 32'(tdo_oe));
    $display("test tap_id done");

    reg_write(`FSL_OFF_KEY, 16'hc3a5);
    reg_write(`FSL_OFF_KEYCMP, 16'hc3a5);
    check("key no enable", 32'h0, 32'(backdoor_key_ok));
    reg_write(`FSL_OFF_CTRL, 16'h0001);
    check("key enabled", 32'h1, 32'(backdoor_key_ok));
    rd_chk("ctrl", `FSL_OFF_CTRL, 16'h0001, 16'h0001);
    rd_chk("key flag", `FSL_OFF_STATUS, 16'h0002, 16'h0002);
    reg_write(`FSL_OFF_KEYCMP, 16'h0000);
    check("key wrong", 32'h0, 32'(backdoor_key_ok));
    rd_chk("unmapped", 4'hf, 16'hffff, 16'h0000);
    $display("test backdoor done");

    rd_chk("sw divider", `FSL_OFF_CLKDIV, 16'h007f, 16'h002a);
    lockout(7'h13);
    tick_period(2 * 1 * 20);
    for (int n = 0; n < 3000 && flash_mass_erase === 1'b1; n++) @(negedge core_clk);
    rd_chk("erase done", `FSL_OFF_STATUS, 16'h0018, 16'h0010);
    lockout(7'h49);
    tick_period(2 * 8 * 10);
    flash_erase_done <= 1'b1;
    repeat (4) @(negedge core_clk);
    check("erase stopped", 32'h0, 32'(flash_mass_erase));
    rd_chk("erase state", `FSL_OFF_STATUS, 16'h0018, 16'h0010);
    flash_erase_done <= 1'b0;
    u_fsl_jtag_host.tap_reset();
    do_reset(`FSL_SEC_UNSEC_WORD);
    check("unsecured", 32'h0, 32'(dbg_read_disable));
    check("sw divider back", 32'h2a, 32'(flash_clock_divider));
    $display("test lockout done");
    finish_test();
  end
endmodule

// ---- verilog/fsl_clk_div.sv ----
// Flash timing clock divider producing one tick per divided period
`timescale 1ns/1ps
`include "fsl_defines.svh"
module fsl_clk_div
  import fsl_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  // Divider request
  fsl_div_if.div_side dv
);
  typedef struct packed {
    logic       half;
    logic [3:0] pre;
    logic [5:0] cnt;
    logic       tick;
  } fsl_div_s;
  fsl_div_s st_r;
  fsl_div_s st_nxt;

  // Input clock is core clock halved, then optional divide by eight, then DIV+1
  always_comb begin
    st_nxt      = st_r;
    st_nxt.tick = 1'b0;
    if (!dv.run) begin
      st_nxt.half = 1'b0;
      st_nxt.pre  = 4'h0;
      st_nxt.cnt  = 6'h00;
    end else begin
      st_nxt.half = ~st_r.half;
      if (st_r.half) begin
        if (dv.divide_by_eight_prescale && st_r.pre != `FSL_PRESCALE_DIV) begin
          st_nxt.pre = st_r.pre + 4'h1;
        end else begin
          st_nxt.pre = 4'h0;
          if (st_r.cnt == dv.div) begin
            st_nxt.cnt  = 6'h00;
            st_nxt.tick = 1'b1;
          end else begin
            st_nxt.cnt = st_r.cnt + 6'h01;
          end
        end
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      st_r <= '0;
    end else if (clk_en) begin
      st_r <= st_nxt;
    end
  end

  assign dv.tick = st_r.tick;

  a_tick_one_cycle: assert property (@(posedge core_clk) disable iff (sys_rst)
    dv.tick |=> !dv.tick) else $error("divider tick longer than one cycle");
endmodule

// ---- verilog/fsl_lockout.sv ----
// Flash security interlock with JTAG TAP and lockout recovery erase
//
// Chosen here: strobed register access and the register addresses.
`timescale 1ns/1ps
`include "fsl_defines.svh"

module fsl_lockout
  import fsl_pkg::*;
(
  // Clock, reset, enable
  input  wire logic                      core_clk,
  input  wire logic                      sys_rst,
  input  wire logic                      clk_en,
  // Register port
  input  wire logic [`FSL_ADDR_W-1:0]    reg_addr,
  input  wire logic [`FSL_DATA_W-1:0]    reg_wdata,
  input  wire logic                      reg_wr,
  input  wire logic                      reg_rd,
  output logic      [`FSL_DATA_W-1:0]    reg_rdata,
  // Flash security bytes and software divider
  input  wire logic [`FSL_DATA_W-1:0]    sec_word,
  input  wire logic [`FSL_DR_W-1:0]      sw_flash_clkdiv,
  input  wire logic                      flash_erase_done,
  // JTAG pins
  input  wire logic                      trst_n,
  input  wire logic                      tck,
  input  wire logic                      tms,
  input  wire logic                      tdi,
  output logic                           tdo,
  output logic                           tdo_oe,
  // Flash and core side
  output logic                           dbg_read_disable,
  output logic                           onchip_debug_port_en,
  output logic                           flash_mass_erase,
  output logic      [`FSL_DR_W-1:0]      flash_clock_divider,
  output logic                           flash_div_tick,
  output logic                           backdoor_key_ok
);

  typedef struct packed {
    logic [2:0]                 tck_s;
    logic [1:0]                 tms_s;
    logic [1:0]                 tdi_s;
    logic [1:0]                 trst_s;
    logic                       boot_done;
    logic                       secure;
    fsl_tap_e                   tap;
    logic [`FSL_IR_W-1:0]       ir_sh;
    logic [`FSL_IR_W-1:0]       ir;
    logic [31:0]                dr_sh;
    logic [`FSL_DR_W-1:0]       jtag_erase_clock_divider;
    logic                       div_loaded;
    fsl_erase_e                 er;
    logic [15:0]                er_cnt;
    logic                       tdo;
    logic                       tdo_oe;
    logic                       backdoor_key_enable;
    logic [`FSL_DATA_W-1:0]     key;
    logic [`FSL_DATA_W-1:0]     key_cmp;
    logic [`FSL_DATA_W-1:0]     rdata;
  } fsl_state_s;

  fsl_state_s st_r;
  fsl_state_s st_nxt;
  fsl_div_if  dv ();

  logic tck_rise;
  logic tck_fall;
  logic tap_rst;

  // ----------------------------------------------------------------
  // Pin synchronisers and test clock edges
  // ----------------------------------------------------------------
  // Synchronised pins; only stage two onward is looked at
  assign tck_rise = st_r.tck_s[1] & ~st_r.tck_s[2];
  assign tck_fall = ~st_r.tck_s[1] & st_r.tck_s[2];
  assign tap_rst  = ~st_r.trst_s[1];

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt        = st_r;
    st_nxt.tck_s  = {st_r.tck_s[1:0], tck};
    st_nxt.tms_s  = {st_r.tms_s[0], tms};
    st_nxt.tdi_s  = {st_r.tdi_s[0], tdi};
    st_nxt.trst_s = {st_r.trst_s[0], trst_n};
    st_nxt.rdata  = '0;

    // Security is sampled once after reset and then frozen
    if (!st_r.boot_done) begin
      st_nxt.boot_done = 1'b1;
      st_nxt.secure    = (sec_word != `FSL_SEC_UNSEC_WORD);
    end

    if (tap_rst) begin
      st_nxt.tap    = FSL_TLR;
      st_nxt.ir     = `FSL_IR_RESET_VAL;
      st_nxt.tdo_oe = 1'b0;
    end else if (tck_rise) begin
      unique case (st_r.tap)
        FSL_TLR:    st_nxt.tap = st_r.tms_s[1] ? FSL_TLR : FSL_RTI;
        FSL_RTI:    st_nxt.tap = st_r.tms_s[1] ? FSL_SEL_DR : FSL_RTI;
        FSL_SEL_DR: st_nxt.tap = st_r.tms_s[1] ? FSL_SEL_IR : FSL_CAP_DR;
        FSL_CAP_DR: st_nxt.tap = st_r.tms_s[1] ? FSL_EX1_DR : FSL_SH_DR;
        FSL_SH_DR:  st_nxt.tap = st_r.tms_s[1] ? FSL_EX1_DR : FSL_SH_DR;
        FSL_EX1_DR: st_nxt.tap = st_r.tms_s[1] ? FSL_UPD_DR : FSL_PAU_DR;
        FSL_PAU_DR: st_nxt.tap = st_r.tms_s[1] ? FSL_EX2_DR : FSL_PAU_DR;
        FSL_EX2_DR: st_nxt.tap = st_r.tms_s[1] ? FSL_UPD_DR : FSL_SH_DR;
        FSL_UPD_DR: st_nxt.tap = st_r.tms_s[1] ? FSL_SEL_DR : FSL_RTI;
        FSL_SEL_IR: st_nxt.tap = st_r.tms_s[1] ? FSL_TLR : FSL_CAP_IR;
        FSL_CAP_IR: st_nxt.tap = st_r.tms_s[1] ? FSL_EX1_IR : FSL_SH_IR;
        FSL_SH_IR:  st_nxt.tap = st_r.tms_s[1] ? FSL_EX1_IR : FSL_SH_IR;
        FSL_EX1_IR: st_nxt.tap = st_r.tms_s[1] ? FSL_UPD_IR : FSL_PAU_IR;
        FSL_PAU_IR: st_nxt.tap = st_r.tms_s[1] ? FSL_EX2_IR : FSL_PAU_IR;
        FSL_EX2_IR: st_nxt.tap = st_r.tms_s[1] ? FSL_UPD_IR : FSL_SH_IR;
        FSL_UPD_IR: st_nxt.tap = st_r.tms_s[1] ? FSL_SEL_DR : FSL_RTI;
      endcase
      unique case (st_r.tap)
        FSL_CAP_IR: st_nxt.ir_sh = {{(`FSL_IR_W-2){1'b0}}, 2'b01};
        FSL_SH_IR:  st_nxt.ir_sh = {st_r.tdi_s[1], st_r.ir_sh[`FSL_IR_W-1:1]};
        FSL_UPD_IR: st_nxt.ir    = st_r.ir_sh;
        FSL_CAP_DR: begin
          // ID stays readable in secure mode; lockout DR captures last value
          if (st_r.ir == `FSL_IR_IDCODE) begin
            st_nxt.dr_sh = `FSL_IDCODE_VAL;
          end else if (st_r.ir == `FSL_IR_LOCKOUT) begin
            st_nxt.dr_sh = {25'h0, st_r.jtag_erase_clock_divider};
          end else begin
            st_nxt.dr_sh = 32'h0;
          end
        end
        FSL_SH_DR: begin
          if (st_r.ir == `FSL_IR_IDCODE) begin
            st_nxt.dr_sh = {st_r.tdi_s[1], st_r.dr_sh[31:1]};
          end else if (st_r.ir == `FSL_IR_LOCKOUT) begin
            st_nxt.dr_sh = {25'h0, st_r.tdi_s[1], st_r.dr_sh[`FSL_DR_W-1:1]};
          end else begin
            st_nxt.dr_sh = {31'h0, st_r.tdi_s[1]};
          end
        end
        FSL_UPD_DR: begin
          if (st_r.ir == `FSL_IR_LOCKOUT) begin
            st_nxt.jtag_erase_clock_divider = st_r.dr_sh[`FSL_DR_W-1:0];
            st_nxt.div_loaded = 1'b1;
          end
        end
        default: begin
        end
      endcase
    end else if (tck_fall) begin
      st_nxt.tdo    = (st_r.tap == FSL_SH_IR) ? st_r.ir_sh[0] : st_r.dr_sh[0];
      st_nxt.tdo_oe = (st_r.tap == FSL_SH_IR) || (st_r.tap == FSL_SH_DR);
    end

    // ----------------------------------------------------------------
    // Erase sequencer
    // ----------------------------------------------------------------
    // Erase runs only with a loaded divider while the TAP idles
    unique case (st_r.er)
      FSL_ER_IDLE: begin
        if (st_r.ir == `FSL_IR_LOCKOUT && st_r.div_loaded && st_r.tap == FSL_RTI && !tap_rst) begin
          st_nxt.er     = FSL_ER_RUN;
          st_nxt.er_cnt = '0;
        end
      end
      FSL_ER_RUN: begin
        if (st_r.tap != FSL_RTI || tap_rst) begin
          st_nxt.er = FSL_ER_IDLE;
        end else if (flash_erase_done || st_r.er_cnt == `FSL_ERASE_TICKS) begin
          st_nxt.er = FSL_ER_DONE;
        end else if (dv.tick) begin
          st_nxt.er_cnt = st_r.er_cnt + 16'h0001;
        end
      end
      FSL_ER_DONE: begin
        // Security stays on until the next chip reset reads blank bytes
        if (tap_rst) begin
          st_nxt.er = FSL_ER_IDLE;
        end
      end
      default: st_nxt.er = FSL_ER_IDLE;
    endcase
    if (tap_rst) begin
      st_nxt.div_loaded = 1'b0;
    end

    // ----------------------------------------------------------------
    // Register port
    // ----------------------------------------------------------------
    if (reg_wr) begin
      unique case (reg_addr)
        `FSL_OFF_CTRL:   st_nxt.backdoor_key_enable = reg_wdata[`FSL_CTRL_BACKDOOR_KEY_ENABLE_BIT];
        `FSL_OFF_KEY:    st_nxt.key     = reg_wdata;
        `FSL_OFF_KEYCMP: st_nxt.key_cmp = reg_wdata;
        default: begin
        end
      endcase
    end
    if (reg_rd) begin
      unique case (reg_addr)
        `FSL_OFF_CTRL:   st_nxt.rdata = {15'h0, st_r.backdoor_key_enable};
        `FSL_OFF_STATUS: st_nxt.rdata = {11'h0, st_r.er, st_r.div_loaded, backdoor_key_ok, st_r.secure};
        `FSL_OFF_CLKDIV: st_nxt.rdata = {9'h0, flash_clock_divider};
        default:         st_nxt.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      st_r        <= '0;
      st_r.secure <= 1'b1;
      st_r.ir     <= `FSL_IR_RESET_VAL;
      st_r.trst_s <= 2'b00;
    end else if (clk_en) begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Divider and outputs
  // ----------------------------------------------------------------
  assign dv.run    = (st_r.er == FSL_ER_RUN);
  assign dv.divide_by_eight_prescale = flash_clock_divider[`FSL_DR_PRDIV_BIT];
  assign dv.div    = flash_clock_divider[`FSL_DR_DIV_MSB:0];

  fsl_clk_div u_div (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .clk_en   (clk_en),
    .dv       (dv)
  );

  assign flash_clock_divider  = (st_r.er != FSL_ER_IDLE) ? st_r.jtag_erase_clock_divider : sw_flash_clkdiv;
  assign flash_div_tick       = dv.tick;
  assign flash_mass_erase     = (st_r.er == FSL_ER_RUN);
  assign dbg_read_disable     = st_r.secure;
  assign onchip_debug_port_en = ~st_r.secure;
  assign backdoor_key_ok      = st_r.backdoor_key_enable && (st_r.key == st_r.key_cmp);
  assign tdo                  = st_r.tdo;
  assign tdo_oe               = st_r.tdo_oe;
  assign reg_rdata            = st_r.rdata;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_sec_frozen: assert property (@(posedge core_clk) disable iff (sys_rst)
    st_r.boot_done && $past(st_r.boot_done) |-> $stable(dbg_read_disable)) else $error("security level changed");
  a_dbg_blocked: assert property (@(posedge core_clk) disable iff (sys_rst)
    dbg_read_disable |-> !onchip_debug_port_en) else $error("debug open while secure");
  a_erase_needs_rti: assert property (@(posedge core_clk) disable iff (sys_rst)
    flash_mass_erase && clk_en |=> st_r.tap == FSL_RTI || !flash_mass_erase) else $error("erase outside idle");
  a_div_override: assert property (@(posedge core_clk) disable iff (sys_rst)
    flash_mass_erase |-> flash_clock_divider == st_r.jtag_erase_clock_divider) else $error("divider not overridden");
  a_key_gated: assert property (@(posedge core_clk) disable iff (sys_rst)
    backdoor_key_ok |-> st_r.backdoor_key_enable) else $error("key access without enable");
  a_erase_loaded: assert property (@(posedge core_clk) disable iff (sys_rst)
    $rose(flash_mass_erase) |-> $past(st_r.div_loaded)) else $error("erase without divider");
  // Compared against the loaded JTAG value, not the mux output that feeds it
  a_prdiv_map: assert property (@(posedge core_clk) disable iff (sys_rst)
    flash_mass_erase |-> dv.divide_by_eight_prescale == st_r.jtag_erase_clock_divider[`FSL_DR_PRDIV_BIT])
    else $error("prescale bit mismapped");
  // Sample edge is the one where boot_done rises; the reset value would look like secure
  a_boot_sample: assert property (@(posedge core_clk) disable iff (sys_rst)
    $rose(st_r.boot_done) |-> dbg_read_disable == ($past(sec_word) != `FSL_SEC_UNSEC_WORD))
    else $error("bad boot sample");
  a_erase_abort: assert property (@(posedge core_clk) disable iff (sys_rst)
    flash_mass_erase && clk_en && st_r.tap != FSL_RTI |=> !flash_mass_erase) else $error("erase kept outside idle");
  a_tdo_released: assert property (@(posedge core_clk) disable iff (sys_rst)
    tap_rst && clk_en |=> !tdo_oe) else $error("tdo driven in tap reset");
endmodule
